/* rmc_pkg.sv */
// Constants, field layout and decode functions for the rail mode control registers.
// Assumes an 8-bit register space reached through a simple write/read strobe port.
package rmc_pkg;

	localparam int RMC_NUM_RAILS = 4;
	localparam int RMC_RAIL_IO = 0;
	localparam int RMC_RAIL_FIVE = 1;
	localparam int RMC_RAIL_DEEP = 2;
	localparam int RMC_RAIL_HUB = 3;

	localparam logic [7:0] RMC_ADDR_IO = 8'h30;
	localparam logic [7:0] RMC_ADDR_FIVE = 8'h31;
	localparam logic [7:0] RMC_ADDR_DEEP = 8'h32;
	localparam logic [7:0] RMC_ADDR_HUB = 8'h33;

	localparam logic [7:0] RMC_RST_IO = 8'h0A;
	localparam logic [7:0] RMC_RST_FIVE = 8'h2A;
	localparam logic [7:0] RMC_RST_DEEP = 8'h2A;
	localparam logic [7:0] RMC_RST_HUB = 8'h0A;

	// Bit 7 of the io core register is read-only zero
	localparam logic [7:0] RMC_WMASK_IO = 8'h7F;
	localparam logic [7:0] RMC_WMASK_FULL = 8'hFF;

	localparam int RMC_MODE_LSB = 0;
	localparam int RMC_EXIT_LSB = 2;
	localparam int RMC_VSEL_LSB = 4;
	localparam int RMC_LP_LSB = 6;
	localparam int RMC_DECAY_BIT = 6;

	localparam logic [1:0] RMC_MODE_OFF = 2'h0;
	localparam logic [1:0] RMC_MODE_FORCED_PULSE_WIDTH_MODE = 2'h3;
	localparam logic [1:0] RMC_EXIT_NONE = 2'h0;
	localparam logic [1:0] RMC_LP_NONE = 2'h0;

	localparam logic [9:0] RMC_IO_MV_00 = 10'h3CF;
	localparam logic [9:0] RMC_IO_MV_01 = 10'h3B6;
	localparam logic [9:0] RMC_IO_MV_10 = 10'h36B;
	localparam logic [9:0] RMC_IO_MV_11 = 10'h352;
	localparam logic [9:0] RMC_IO_MV_DECAY = 10'h000;

	// Signed percent offsets from nominal
	localparam logic signed [3:0] RMC_PCT_P3 = 4'sh3;
	localparam logic signed [3:0] RMC_PCT_P2 = 4'sh2;
	localparam logic signed [3:0] RMC_PCT_0 = 4'sh0;
	localparam logic signed [3:0] RMC_PCT_M2 = 4'shE;
	localparam logic signed [3:0] RMC_PCT_M3 = 4'shD;
	localparam logic signed [3:0] RMC_PCT_M4 = 4'shC;

	function automatic logic [9:0] rmc_io_mv(input logic [1:0] sel);
		case (sel)
			2'h0: rmc_io_mv = RMC_IO_MV_00;
			2'h1: rmc_io_mv = RMC_IO_MV_01;
			2'h2: rmc_io_mv = RMC_IO_MV_10;
			default: rmc_io_mv = RMC_IO_MV_11;
		endcase
	endfunction : rmc_io_mv

	function automatic logic signed [3:0] rmc_vsel_pct(input logic [1:0] sel);
		case (sel)
			2'h0: rmc_vsel_pct = RMC_PCT_P3;
			2'h1: rmc_vsel_pct = RMC_PCT_P2;
			2'h2: rmc_vsel_pct = RMC_PCT_0;
			default: rmc_vsel_pct = RMC_PCT_M2;
		endcase
	endfunction : rmc_vsel_pct

	function automatic logic signed [3:0] rmc_lp_pct(input logic [1:0] sel);
		case (sel)
			2'h1: rmc_lp_pct = RMC_PCT_M4;
			2'h2: rmc_lp_pct = RMC_PCT_M3;
			default: rmc_lp_pct = RMC_PCT_M2;
		endcase
	endfunction : rmc_lp_pct

endpackage : rmc_pkg

/* rmc_sleep_sync.sv */
// Two-flop synchroniser for the sleep pin with edge detection.
// Assumes the pin is asynchronous to clk_sys_in; pulses last one cycle.
`timescale 1ns/1ps
`default_nettype none
module rmc_sleep_sync (
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic sleep_state_n_in,
	output logic asleep_out,
	output logic fall_out,
	output logic rise_out
);
	logic meta_q;
	logic sync_q;
	logic level_q;

	// Reset to deasserted (high) so release does not fake an edge
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			meta_q <= 1'b1;
			sync_q <= 1'b1;
			level_q <= 1'b1;
		end else begin
			meta_q <= sleep_state_n_in;
			sync_q <= meta_q;
			level_q <= sync_q;
		end
	end

	assign fall_out = level_q & ~sync_q;
	assign rise_out = ~level_q & sync_q;
	assign asleep_out = ~level_q;
endmodule : rmc_sleep_sync
`default_nettype wire

/* rmc_rail_reg.sv */
// One 8-bit rail control register with standby-exit mode reload.
// Assumes the write strobe and exit pulse are on clk_sys_in.
`timescale 1ns/1ps
`default_nettype none
module rmc_rail_reg #(
	parameter logic [7:0] RESET_VAL = 8'h0A,
	parameter logic [7:0] WR_MASK = 8'hFF
) (
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic wr_en_in,
	input wire logic [7:0] wdata_in,
	input wire logic exit_in,
	output logic [7:0] reg_out
);
	logic [7:0] reg_q;
	logic [7:0] reg_d;
	logic [1:0] exit_field;

	assign exit_field = reg_q[rmc_pkg::RMC_EXIT_LSB +: 2];

	always_comb begin
		reg_d = reg_q;
		if (wr_en_in) begin
			reg_d = wdata_in & WR_MASK;
		end
		// Reload beats a same-cycle host write of the mode bits
		if (exit_in && exit_field != rmc_pkg::RMC_EXIT_NONE) begin
			reg_d[rmc_pkg::RMC_MODE_LSB +: 2] = exit_field;
		end
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			reg_q <= RESET_VAL;
		end else begin
			reg_q <= reg_d;
		end
	end

	assign reg_out = reg_q;
endmodule : rmc_rail_reg
`default_nettype wire

/* rmc_rail_mode_ctrl.sv */
// Rail mode control register bank: four rail registers, sleep handling, rail targets.
// Assumes a serial-bus slave upstream presents byte writes/reads on clk_sys_in.
// Behaviour
// - Decay enabled at sleep entry and still enabled, while asleep: io rail 0V, good held
// - Decay disabled: io rail stays at select
// - Io select maps to 975/950/875/850 mV
// - Sleep exit copies nonzero exit field into mode
// - Exit field 00 leaves mode bits unchanged
// - Exit 01/10 auto, 11 forced pulse-width except on hub
// - Mode 00 off, 01/10 auto, 11 forced except on hub
// - Sleep entry applies low-power setpoint offsets
// - Select maps +3, +2, 0, -2 percent
// - Five volt register 0x31, reset 0x2A
// - Deep-sleep register 0x32, reset 0x2A
// - Hub register 0x33, reset 0x0A
// - Io bit 7 reserved read-only zero
// - Hub mode 00 off, others on
// - Io register 0x30, reset 0x0A
`timescale 1ns/1ps
`default_nettype none
module rmc_rail_mode_ctrl (
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic sleep_state_n_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_wr_en_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_rd_en_in,
	output logic [7:0] reg_rdata_out,
	output logic [3:0] rail_enable_out,
	output logic [3:0] rail_forced_pwm_out,
	output logic [9:0] io_rail_mv_out,
	output logic io_rail_decay_out,
	output logic io_rail_good_hold_out,
	output logic signed [3:0] five_volt_pct_out,
	output logic signed [3:0] deep_sleep_pct_out,
	output logic sleep_active_out
);
	localparam logic [7:0] ADDR [rmc_pkg::RMC_NUM_RAILS] = '{rmc_pkg::RMC_ADDR_IO,
		rmc_pkg::RMC_ADDR_FIVE, rmc_pkg::RMC_ADDR_DEEP, rmc_pkg::RMC_ADDR_HUB};
	localparam logic [7:0] RSTV [rmc_pkg::RMC_NUM_RAILS] = '{rmc_pkg::RMC_RST_IO,
		rmc_pkg::RMC_RST_FIVE, rmc_pkg::RMC_RST_DEEP, rmc_pkg::RMC_RST_HUB};
	localparam logic [7:0] WMSK [rmc_pkg::RMC_NUM_RAILS] = '{rmc_pkg::RMC_WMASK_IO,
		rmc_pkg::RMC_WMASK_FULL, rmc_pkg::RMC_WMASK_FULL, rmc_pkg::RMC_WMASK_FULL};

	logic asleep;
	logic sleep_fall;
	logic sleep_rise;
	logic [7:0] regs [rmc_pkg::RMC_NUM_RAILS];
	logic [3:0] hit;
	logic [1:0] lp_five_q;
	logic [1:0] lp_deep_q;
	logic decay_armed_q;
	logic decay_now;
	logic [1:0] mode [rmc_pkg::RMC_NUM_RAILS];

	rmc_sleep_sync u_sync (
		.clk_sys_in(clk_sys_in),
		.nrst_in(nrst_in),
		.sleep_state_n_in(sleep_state_n_in),
		.asleep_out(asleep),
		.fall_out(sleep_fall),
		.rise_out(sleep_rise)
	);

	genvar gi;
	generate
		for (gi = 0; gi < rmc_pkg::RMC_NUM_RAILS; gi++) begin : g_rail
			assign hit[gi] = (reg_addr_in == ADDR[gi]);
			assign mode[gi] = regs[gi][rmc_pkg::RMC_MODE_LSB +: 2];
			rmc_rail_reg #(
				.RESET_VAL(RSTV[gi]),
				.WR_MASK(WMSK[gi])
			) u_reg (
				.clk_sys_in(clk_sys_in),
				.nrst_in(nrst_in),
				.wr_en_in(reg_wr_en_in & hit[gi]),
				.wdata_in(reg_wdata_in),
				.exit_in(sleep_rise),
				.reg_out(regs[gi])
			);
			// Hub rail has no forced mode; any nonzero mode just enables it
			always_ff @(posedge clk_sys_in or negedge nrst_in) begin
				if (!nrst_in) begin
					rail_enable_out[gi] <= 1'b0;
					rail_forced_pwm_out[gi] <= 1'b0;
				end else begin
					rail_enable_out[gi] <= (mode[gi] != rmc_pkg::RMC_MODE_OFF);
					rail_forced_pwm_out[gi] <= (gi != rmc_pkg::RMC_RAIL_HUB) &&
						(mode[gi] == rmc_pkg::RMC_MODE_FORCED_PULSE_WIDTH_MODE);
				end
			end
		end
	endgenerate

	// Read data registered; unmapped addresses read zero
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			reg_rdata_out <= 8'h00;
		end else if (reg_rd_en_in) begin
			case (reg_addr_in)
				rmc_pkg::RMC_ADDR_IO: reg_rdata_out <= regs[rmc_pkg::RMC_RAIL_IO];
				rmc_pkg::RMC_ADDR_FIVE: reg_rdata_out <= regs[rmc_pkg::RMC_RAIL_FIVE];
				rmc_pkg::RMC_ADDR_DEEP: reg_rdata_out <= regs[rmc_pkg::RMC_RAIL_DEEP];
				rmc_pkg::RMC_ADDR_HUB: reg_rdata_out <= regs[rmc_pkg::RMC_RAIL_HUB];
				default: reg_rdata_out <= 8'h00;
			endcase
		end
	end

	// Setpoints latched at sleep entry so later writes wait for the next entry
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			lp_five_q <= rmc_pkg::RMC_LP_NONE;
			lp_deep_q <= rmc_pkg::RMC_LP_NONE;
		end else if (sleep_fall) begin
			lp_five_q <= regs[rmc_pkg::RMC_RAIL_FIVE][rmc_pkg::RMC_LP_LSB +: 2];
			lp_deep_q <= regs[rmc_pkg::RMC_RAIL_DEEP][rmc_pkg::RMC_LP_LSB +: 2];
		end else if (sleep_rise) begin
			lp_five_q <= rmc_pkg::RMC_LP_NONE;
			lp_deep_q <= rmc_pkg::RMC_LP_NONE;
		end
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			decay_armed_q <= 1'b0;
		end else if (sleep_fall) begin
			decay_armed_q <= regs[rmc_pkg::RMC_RAIL_IO][rmc_pkg::RMC_DECAY_BIT];
		end else if (sleep_rise) begin
			decay_armed_q <= 1'b0;
		end
	end

	// Clearing the enable mid-sleep cancels decay at once
	assign decay_now = decay_armed_q & asleep & regs[rmc_pkg::RMC_RAIL_IO][rmc_pkg::RMC_DECAY_BIT];

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			io_rail_mv_out <= rmc_pkg::RMC_IO_MV_DECAY;
			io_rail_decay_out <= 1'b0;
			io_rail_good_hold_out <= 1'b0;
		end else begin
			io_rail_mv_out <= decay_now ? rmc_pkg::RMC_IO_MV_DECAY :
				rmc_pkg::rmc_io_mv(regs[rmc_pkg::RMC_RAIL_IO][rmc_pkg::RMC_VSEL_LSB +: 2]);
			io_rail_decay_out <= decay_now;
			io_rail_good_hold_out <= decay_now;
		end
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			five_volt_pct_out <= rmc_pkg::RMC_PCT_0;
			deep_sleep_pct_out <= rmc_pkg::RMC_PCT_0;
		end else begin
			five_volt_pct_out <= (asleep && lp_five_q != rmc_pkg::RMC_LP_NONE) ?
				rmc_pkg::rmc_lp_pct(lp_five_q) :
				rmc_pkg::rmc_vsel_pct(regs[rmc_pkg::RMC_RAIL_FIVE][rmc_pkg::RMC_VSEL_LSB +: 2]);
			deep_sleep_pct_out <= (asleep && lp_deep_q != rmc_pkg::RMC_LP_NONE) ?
				rmc_pkg::rmc_lp_pct(lp_deep_q) :
				rmc_pkg::rmc_vsel_pct(regs[rmc_pkg::RMC_RAIL_DEEP][rmc_pkg::RMC_VSEL_LSB +: 2]);
		end
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sleep_active_out <= 1'b0;
		end else begin
			sleep_active_out <= asleep;
		end
	end

	logic run_q;

	// Checks start one edge after release; outputs still hold reset values at the release edge
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			run_q <= 1'b0;
		end else begin
			run_q <= 1'b1;
		end
	end

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!nrst_in || !run_q);

	AST_IO_DECAY_ZERO: assert property (decay_now |=> io_rail_mv_out == 10'h000 && io_rail_good_hold_out)
		else $error("io rail not at 0V with good held during decay");
	AST_IO_NO_DECAY: assert property (!regs[0][6] |=> !io_rail_decay_out && io_rail_mv_out != 10'h000)
		else $error("io rail decayed with decay disabled");
	AST_IO_MAP: assert property (!decay_now && regs[0][5:4] == 2'h2 |=> io_rail_mv_out == rmc_pkg::RMC_IO_MV_10)
		else $error("io select 10 not 875 mV");
	AST_EXIT_RELOAD: assert property (sleep_rise && regs[1][3:2] != 2'h0 |=> regs[1][1:0] == $past(regs[1][3:2]))
		else $error("exit field not copied to mode");
	AST_EXIT_NONE: assert property (sleep_rise && regs[3][3:2] == 2'h0 && !(reg_wr_en_in && hit[3])
		|=> $stable(regs[3]))
		else $error("exit field 00 changed mode");
	AST_MODE_DECODE: assert property (1'b1 |=> rail_forced_pwm_out[2] == ($past(regs[2][1:0]) == 2'h3)
		&& rail_enable_out[2] == ($past(regs[2][1:0]) != 2'h0))
		else $error("deep-sleep mode decode wrong");
	AST_LP_APPLY: assert property (sleep_fall && regs[1][7:6] == 2'h1 ##1 asleep |=> five_volt_pct_out == 4'shC)
		else $error("five volt setpoint not -4 percent");
	AST_VSEL_MAP: assert property (!asleep && regs[2][5:4] == 2'h0 |=> deep_sleep_pct_out == 4'sh3)
		else $error("deep-sleep select 00 not +3 percent");
	AST_RESERVED: assert property (reg_rd_en_in && reg_addr_in == 8'h30 |=> !reg_rdata_out[7])
		else $error("io reserved bit read as one");
	AST_HUB_EN: assert property (1'b1 |=> rail_enable_out[3] == ($past(regs[3][1:0]) != 2'h0)
		&& !rail_forced_pwm_out[3])
		else $error("hub enable decode wrong");
	AST_SYNC_LAT: assert property ($fell(sleep_state_n_in) ##1 !sleep_state_n_in[*2] |-> ##[0:1] sleep_fall)
		else $error("sleep entry not detected in time");
	AST_RESET_VAL: assert property ($rose(nrst_in) |-> regs[1] == 8'h2A && regs[2] == 8'h2A)
		else $error("register reset value wrong");

	COV_DECAY: cover property (decay_now ##1 sleep_rise);
	COV_RELOAD_FORCED_PULSE_WIDTH_MODE: cover property (sleep_rise && regs[0][3:2] == 2'h3);
	COV_LP_DEEP: cover property (sleep_fall && regs[2][7:6] == 2'h3);
endmodule : rmc_rail_mode_ctrl
`default_nettype wire

/* rmc_host_model.sv */
// Host and platform model: register strobes and the sleep pin.
// Assumes the bench calls its tasks; every drive follows a rising edge.
`timescale 1ns/1ps
`default_nettype none
module rmc_host_model (
	input wire logic clk_sys_in,
	output logic sleep_state_n_out,
	output logic [7:0] reg_addr_out,
	output logic reg_wr_en_out,
	output logic [7:0] reg_wdata_out,
	output logic reg_rd_en_out
);
	localparam int FORCED_PULSE_WIDTH_MODE_GAP_CYC = 80;
	initial begin
		sleep_state_n_out = 1'b1;
		reg_addr_out = 8'h00;
		reg_wr_en_out = 1'b0;
		reg_wdata_out = 8'h00;
		reg_rd_en_out = 1'b0;
	end
	task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data);
		@(posedge clk_sys_in);
		reg_addr_out <= addr;
		reg_wdata_out <= data;
		reg_wr_en_out <= wr;
		reg_rd_en_out <= !wr;
		@(posedge clk_sys_in);
		reg_wr_en_out <= 1'b0;
		reg_rd_en_out <= 1'b0;
		// Released bus shows no stale value
		reg_addr_out <= ~addr;
		reg_wdata_out <= ~data;
	endtask : access
	// 2us at 40 MHz; avoids ringing on a direct forced-to-decay step
	task automatic forced_pulse_width_mode_gap();
		repeat (FORCED_PULSE_WIDTH_MODE_GAP_CYC) @(posedge clk_sys_in);
	endtask : forced_pulse_width_mode_gap
	task automatic set_sleep(input logic lvl);
		@(posedge clk_sys_in);
		sleep_state_n_out <= lvl;
	endtask : set_sleep
endmodule : rmc_host_model
`default_nettype wire

/* rmc_rail_mode_ctrl_tb_top.sv */
// Bench for the rail mode control bank: register, mode and sleep scenarios.
// Assumes rmc_host_model drives every bus input and the sleep pin.
`timescale 1ns/1ps
`default_nettype none
module rmc_rail_mode_ctrl_tb_top;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic rd_pend = 1'b0;
	logic snap = 1'b0;
	logic sl_n, wr_en, rd_en, dec, hold, sa;
	logic [7:0] addr, wdata, rdata;
	logic [3:0] en, fp, p5, p3;
	logic [9:0] mv;
	int failures = 0;
	int checks = 0;
	int i;
	logic [7:0] rq[$];
	logic [28:0] sq[$];
	logic [7:0] r = 8'h12;
	logic [1:0] s5;
	logic [9:0] mvt[4] = '{10'h3CF, 10'h3B6, 10'h36B, 10'h352};
	logic [3:0] vp[4] = '{4'h3, 4'h2, 4'h0, 4'hE};
	always #12.5 clk = ~clk;
	rmc_host_model rmc_host_model_inst (.clk_sys_in(clk), .sleep_state_n_out(sl_n), .reg_addr_out(addr),
		.reg_wr_en_out(wr_en), .reg_wdata_out(wdata), .reg_rd_en_out(rd_en));
	rmc_rail_mode_ctrl rmc_rail_mode_ctrl_inst (.clk_sys_in(clk), .nrst_in(nrst), .sleep_state_n_in(sl_n),
		.reg_addr_in(addr), .reg_wr_en_in(wr_en), .reg_wdata_in(wdata), .reg_rd_en_in(rd_en),
		.reg_rdata_out(rdata), .rail_enable_out(en), .rail_forced_pwm_out(fp), .io_rail_mv_out(mv),
		.io_rail_decay_out(dec), .io_rail_good_hold_out(hold), .five_volt_pct_out(p5),
		.deep_sleep_pct_out(p3), .sleep_active_out(sa));
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr
	// Hold output follows decay in every scenario here
	function automatic logic [28:0] st(input logic [3:0] e, input logic [3:0] f, input logic [9:0] m,
		input logic d, input logic [3:0] a, input logic [3:0] b, input logic s);
		return {e, f, m, d, d, a, b, s};
	endfunction : st
	task automatic cmp_rd(input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %0t read %h expected %h", $time, g, e);
		end
	endtask : cmp_rd
	task automatic cmp_st(input logic [28:0] e, input logic [28:0] g);
		checks++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %0t status %h expected %h", $time, g, e);
		end
	endtask : cmp_st
	task automatic test_done();
		$display("Counts: %0d checks, %0d failures", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : test_done
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		rq.push_back(e);
		rmc_host_model_inst.access(1'b0, a, 8'h00);
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		rmc_host_model_inst.access(1'b1, a, d);
	endtask : wr
	// Five edges cover the slowest path, sleep edge to enable outputs
	task automatic chk(input logic [28:0] e);
		repeat (5) @(posedge clk);
		sq.push_back(e);
		snap <= 1'b1;
		@(posedge clk);
		snap <= 1'b0;
	endtask : chk
	always @(posedge clk) begin
		if (rd_pend) begin
			cmp_rd(rq.pop_front(), rdata);
		end
		if (snap) begin
			cmp_st(sq.pop_front(), {en, fp, mv, dec, hold, p5, p3, sa});
		end
		rd_pend <= rd_en;
	end
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		$display("CHECK FAILED %0t run timed out", $time);
		test_done();
	end
	initial begin
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		chk(st(4'hF, 4'h0, 10'h3CF, 1'b0, 4'h0, 4'h0, 1'b0));
		rd(8'h30, 8'h0A);
		rd(8'h31, 8'h2A);
		rd(8'h32, 8'h2A);
		rd(8'h33, 8'h0A);
		rd(8'h34, 8'h00);
		wr(8'h30, 8'hFF);
		rd(8'h30, 8'h7F);
		$display("Test reset and reserved done");
		for (i = 0; i < 4; i++) begin
			wr(8'h30, {2'b00, i[1:0], 4'hA});
			chk(st(4'hF, 4'h0, mvt[i], 1'b0, 4'h0, 4'h0, 1'b0));
		end
		for (i = 0; i < 4; i++) begin
			wr(8'h30, {6'h02, i[1:0]});
			wr(8'h31, {6'h2A, i[1:0]});
			wr(8'h32, {6'h2A, i[1:0]});
			wr(8'h33, {6'h2A, i[1:0]});
			rd(8'h33, {6'h2A, i[1:0]});
			chk(st((i == 0) ? 4'h0 : 4'hF, (i == 3) ? 4'h7 : 4'h0, 10'h3CF, 1'b0, 4'h0, 4'h0, 1'b0));
		end
		$display("Test modes done");
		for (i = 0; i < 4; i++) begin
			r = lfsr(r);
			wr(8'h31, {r[7:4], 4'hA});
			rd(8'h31, {r[7:4], 4'hA});
			s5 = r[5:4];
			r = lfsr(r);
			wr(8'h32, {r[7:4], 4'hA});
			chk(st(4'hF, 4'h1, 10'h3CF, 1'b0, vp[s5], vp[r[5:4]], 1'b0));
		end
		$display("Test voltage select done");
		wr(8'h30, 8'h0A);
		rmc_host_model_inst.forced_pulse_width_mode_gap();
		wr(8'h30, 8'h56);
		wr(8'h31, 8'h4E);
		wr(8'h32, 8'h31);
		wr(8'h33, 8'h07);
		chk(st(4'hF, 4'h0, 10'h3B6, 1'b0, 4'h3, 4'hE, 1'b0));
		rmc_host_model_inst.set_sleep(1'b0);
		chk(st(4'hF, 4'h0, 10'h000, 1'b1, 4'hC, 4'hE, 1'b1));
		rmc_host_model_inst.set_sleep(1'b1);
		chk(st(4'hF, 4'h2, 10'h3B6, 1'b0, 4'h3, 4'hE, 1'b0));
		rd(8'h30, 8'h55);
		rd(8'h31, 8'h4F);
		rd(8'h32, 8'h31);
		rd(8'h33, 8'h05);
		wr(8'h30, 8'h16);
		rmc_host_model_inst.set_sleep(1'b0);
		chk(st(4'hF, 4'h2, 10'h3B6, 1'b0, 4'hC, 4'hE, 1'b1));
		rmc_host_model_inst.set_sleep(1'b1);
		chk(st(4'hF, 4'h2, 10'h3B6, 1'b0, 4'h3, 4'hE, 1'b0));
		$display("Test sleep done");
		test_done();
	end
endmodule : rmc_rail_mode_ctrl_tb_top
`default_nettype wire
